// ===== hdl/imps_ctrl.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "imps_consts.svh"

module imps_ctrl
   import imps_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire imps_bus_req_t busReq,
   output logic [15:0]        busRdata,
   input  wire logic          pwrSaveExec,
   input  wire logic          pwrSaveIdleOp,
   input  wire imps_wake_t    wake,
   input  wire logic          wdtEnable,
   input  wire logic          fscmEnable,
   output logic               cpuRun,
   output logic               cpuClkEn,
   output logic               wdtClear,
   output logic               lprcRun,
   output logic               timer1Run,
   output logic [7:0]         periphRun,
   output logic [3:0]         dmaChanEn,
   output imps_resume_t       resumeInfo
);

   // ****************************************
   // Declarations
   // ****************************************
   imps_state_t  state_q;
   imps_state_t  state_d;
   logic         enterReq;
   logic         wakeNow;
   logic         resumeDone;
   logic         heldIrq_q;
   logic         wakeByIrq_q;
   logic         wakeByWdt_q;
   logic         dmaDis_q;
   logic         timer_stop_in_idle_q;
   logic [7:0]   idleStop_q;
   logic [15:0]  busRdata_q;
   logic         cpuRun_q;
   logic         cpuClkEn_q;
   logic         wdtClear_q;
   logic         lprcRun_q;
   logic         timer1Run_q;
   logic [7:0]   periphRun_q;
   logic [3:0]   dmaChanEn_q;
   imps_resume_t resumeInfo_q;
   logic         inIdle;

   function automatic logic isWrite(input imps_bus_req_t req, input logic [7:0] addr);
      isWrite = req.we && (req.addr == addr);
   endfunction : isWrite

   // ****************************************
   // Sequencing
   // ****************************************
   assign enterReq = pwrSaveExec && pwrSaveIdleOp;
   // Held interrupt counts as a wake source only once idle is reached
   assign wakeNow  = wake.irq || wake.wdtTimeout || heldIrq_q;
   assign inIdle   = (state_q == IMPS_ENTER) || (state_q == IMPS_IDLE);

   always_comb begin
      state_d = state_q;
      case (state_q)
         IMPS_RUN: begin
            if (enterReq) begin
               state_d = IMPS_ENTER;
            end
         end
         IMPS_ENTER: begin
            state_d = IMPS_IDLE;
         end
         IMPS_IDLE: begin
            if (wakeNow) begin
               state_d = IMPS_RESUME;
            end
         end
         IMPS_RESUME: begin
            if (resumeDone) begin
               state_d = IMPS_RUN;
            end
         end
         default: begin
            state_d = IMPS_RUN;
         end
      endcase
   end

   // Reset alone already brings the core back to run
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= IMPS_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   imps_resume_timer imps_resume_timer_i (
      .clk   (clk),
      .rst_n (rst_n),
      .start ((state_q == IMPS_IDLE) && wakeNow),
      .done  (resumeDone)
   );

   // ****************************************
   // Held interrupt and wake cause
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         heldIrq_q <= 1'b0;
      end else if ((state_q == IMPS_RUN && enterReq) || state_q == IMPS_ENTER) begin
         heldIrq_q <= heldIrq_q || wake.irq;
      end else if (state_q == IMPS_IDLE && wakeNow) begin
         heldIrq_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wakeByIrq_q <= 1'b0;
         wakeByWdt_q <= 1'b0;
      end else if (state_q == IMPS_IDLE && wakeNow) begin
         wakeByIrq_q <= wake.irq || heldIrq_q;
         wakeByWdt_q <= wake.wdtTimeout;
      end
   end

   // ****************************************
   // CPU clock, fetch and watchdog
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cpuRun_q   <= 1'b1;
         cpuClkEn_q <= 1'b1;
      end else begin
         case (state_q)
            IMPS_RUN: begin
               cpuRun_q <= !enterReq;
            end
            IMPS_ENTER: begin
               cpuClkEn_q <= 1'b0;
            end
            IMPS_IDLE: begin
               cpuClkEn_q <= wakeNow;
            end
            IMPS_RESUME: begin
               cpuRun_q <= resumeDone;
            end
            default: begin
               cpuRun_q <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wdtClear_q <= 1'b0;
      end else begin
         wdtClear_q <= (state_q == IMPS_RUN) && enterReq;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         resumeInfo_q <= '0;
      end else begin
         resumeInfo_q.valid <= (state_q == IMPS_RESUME) && resumeDone;
         resumeInfo_q.toIsr <= wakeByIrq_q;
      end
   end

   // ****************************************
   // Clocks to peripherals
   // ****************************************
   // Kept on outside idle too; the clock block owns the real gating
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lprcRun_q <= 1'b0;
      end else begin
         lprcRun_q <= wdtEnable || fscmEnable;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timer1Run_q <= 1'b1;
         periphRun_q <= 8'hff;
      end else begin
         timer1Run_q <= !(inIdle && timer_stop_in_idle_q);
         periphRun_q <= ~(idleStop_q & {8{inIdle}});
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dmaChanEn_q <= 4'hf;
      end else begin
         dmaChanEn_q <= {`IMPS_NUM_DMA{!dmaDis_q}};
      end
   end

   // ****************************************
   // Register bus
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dmaDis_q <= `IMPS_RST_DMA_DIS;
      end else if (isWrite(busReq, `IMPS_ADDR_PDC7)) begin
         dmaDis_q <= busReq.wdata[`IMPS_DMA_DIS_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timer_stop_in_idle_q <= `IMPS_RST_TIMER_STOP_IN_IDLE;
      end else if (isWrite(busReq, `IMPS_ADDR_TMR1CTL)) begin
         timer_stop_in_idle_q <= busReq.wdata[`IMPS_TIMER_STOP_IN_IDLE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         idleStop_q <= `IMPS_RST_IDLESTOP;
      end else if (isWrite(busReq, `IMPS_ADDR_IDLESTOP)) begin
         idleStop_q <= busReq.wdata[7:0];
      end
   end

   // Unmapped and write-only cycles answer zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busRdata_q <= 16'h0000;
      end else begin
         busRdata_q <= 16'h0000;
         if (busReq.re) begin
            case (busReq.addr)
               `IMPS_ADDR_PDC7: begin
                  busRdata_q[`IMPS_DMA_DIS_BIT] <= dmaDis_q;
               end
               `IMPS_ADDR_TMR1CTL: begin
                  busRdata_q[`IMPS_TIMER_STOP_IN_IDLE_BIT] <= timer_stop_in_idle_q;
               end
               `IMPS_ADDR_IDLESTOP: begin
                  busRdata_q[7:0] <= idleStop_q;
               end
               `IMPS_ADDR_STATUS: begin
                  busRdata_q[`IMPS_ST_IDLE_BIT] <= inIdle;
                  busRdata_q[`IMPS_ST_IRQ_BIT]  <= wakeByIrq_q;
                  busRdata_q[`IMPS_ST_WDT_BIT]  <= wakeByWdt_q;
               end
               default: begin
                  busRdata_q <= 16'h0000;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign busRdata   = busRdata_q;
   assign cpuRun     = cpuRun_q;
   assign cpuClkEn   = cpuClkEn_q;
   assign wdtClear   = wdtClear_q;
   assign lprcRun    = lprcRun_q;
   assign timer1Run  = timer1Run_q;
   assign periphRun  = periphRun_q;
   assign dmaChanEn  = dmaChanEn_q;
   assign resumeInfo = resumeInfo_q;

   // ****************************************
   // Assertions
   // ****************************************
   localparam int ResumeMin = `IMPS_RESUME_MIN;
   localparam int ResumeMax = `IMPS_RESUME_MAX;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_idle_no_fetch: assert property ((state_q == IMPS_IDLE) |-> !cpuRun_q && !cpuClkEn_q)
      else $error("cpu fetching while idle");

   a_wdt_clear_entry: assert property ((state_q == IMPS_RUN && enterReq) |=> wdtClear_q ##1 !wdtClear_q)
      else $error("watchdog not cleared once on idle entry");

   a_periph_default_run: assert property ((state_q == IMPS_IDLE && idleStop_q == 8'h00) |=> periphRun_q == 8'hff)
      else $error("peripheral stopped without its stop bit");

   a_low_power_rc_clock_kept_on: assert property ((state_q == IMPS_IDLE && (wdtEnable || fscmEnable)) |=> lprcRun_q)
      else $error("low-power clock dropped while needed");

   a_wake_exit: assert property ((state_q == IMPS_IDLE && (wake.irq || wake.wdtTimeout)) |=> state_q == IMPS_RESUME)
      else $error("wake event did not leave idle");

   // Only a wake counts; a reset in idle also raises both enables
   a_resume_delay: assert property (($rose(cpuClkEn_q) && state_q == IMPS_RESUME)
      |-> ##[ResumeMin:ResumeMax] $rose(cpuRun_q))
      else $error("execution did not restart two to four cycles after clock");

   a_resume_vector: assert property (($rose(cpuRun_q) && $past(state_q) == IMPS_RESUME)
      |-> resumeInfo_q.valid && resumeInfo_q.toIsr == $past(wakeByIrq_q))
      else $error("resume target not reported with restart");

   a_timer_stop: assert property ((state_q == IMPS_IDLE && timer_stop_in_idle_q) |=> !timer1Run_q)
      else $error("first timer running in idle with stop bit set");

   a_held_irq_wake: assert property ((state_q == IMPS_ENTER && wake.irq) |=> state_q == IMPS_IDLE ##1 state_q == IMPS_RESUME)
      else $error("coincident interrupt not held until idle");

   a_dma_disable: assert property (dmaDis_q |=> dmaChanEn_q == 4'h0)
      else $error("dma channels enabled while disabled");

   a_entry_only_cmd: assert property ((state_q == IMPS_RUN && !enterReq) |=> state_q == IMPS_RUN)
      else $error("idle entered without the power-save instruction");

   c_wake_by_irq: cover property (state_q == IMPS_IDLE && wake.irq ##[1:6] resumeInfo_q.valid && resumeInfo_q.toIsr);
   c_wake_by_wdt: cover property (state_q == IMPS_IDLE && wake.wdtTimeout && !wake.irq && !heldIrq_q);
   c_held_irq: cover property (state_q == IMPS_ENTER && wake.irq);
   c_dma_off: cover property ($rose(dmaDis_q));

endmodule : imps_ctrl

`default_nettype wire

// ===== hdl/imps_consts.svh
`ifndef IMPS_CONSTS_SVH
`define IMPS_CONSTS_SVH
// Operation
// - While idle the CPU fetches and executes no instructions until a wake-up event.
// - Entering idle clears the watchdog timer count once.
// - The system clock keeps running in idle and every peripheral keeps running unless told to stop.
// - The low-power RC clock stays on in idle whenever the watchdog or the clock monitor is enabled.
// - Idle ends on an enabled interrupt, on any reset or on a watchdog time-out.
// - On wake the CPU clock returns first and execution restarts two to four cycles later.
// - Execution resumes after the power-save instruction, or at the service routine when an interrupt woke it.
// - Each peripheral has a stop-in-idle bit; for the first timer it is bit 13 of its control register.
// - An interrupt during the power-save instruction waits until idle is entered, then wakes the device.
// - One read/write bit 4, reset to zero, disables all four DMA channels when set.

// ****************************************
// Register offsets
// ****************************************
`define IMPS_ADDR_PDC7      8'h00
`define IMPS_ADDR_TMR1CTL   8'h02
`define IMPS_ADDR_IDLESTOP  8'h04
`define IMPS_ADDR_STATUS    8'h06

// ****************************************
// Field positions and reset values
// ****************************************
`define IMPS_DMA_DIS_BIT    4
`define IMPS_TIMER_STOP_IN_IDLE_BIT      13
`define IMPS_ST_IDLE_BIT    0
`define IMPS_ST_IRQ_BIT     1
`define IMPS_ST_WDT_BIT     2
`define IMPS_RST_DMA_DIS    1'b0
`define IMPS_RST_TIMER_STOP_IN_IDLE      1'b0
`define IMPS_RST_IDLESTOP   8'h00

// ****************************************
// Sizes and timing
// ****************************************
`define IMPS_NUM_PERIPH     8
`define IMPS_NUM_DMA        4
`define IMPS_RESUME_MIN     2
`define IMPS_RESUME_MAX     4
`define IMPS_RESUME_CYC     3'h3

`endif

// ===== hdl/imps_pkg.sv
`default_nettype none

package imps_pkg;

   typedef enum logic [1:0] {
      IMPS_RUN    = 2'b00,
      IMPS_ENTER  = 2'b01,
      IMPS_IDLE   = 2'b10,
      IMPS_RESUME = 2'b11
   } imps_state_t;

   typedef struct packed {
      logic irq;
      logic wdtTimeout;
   } imps_wake_t;

   typedef struct packed {
      logic valid;
      logic toIsr;
   } imps_resume_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        we;
      logic        re;
   } imps_bus_req_t;

endpackage : imps_pkg

`default_nettype wire

// ===== hdl/imps_resume_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "imps_consts.svh"

module imps_resume_timer (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      done
);

   logic [2:0] cnt_q;

   // ****************************************
   // Restart countdown
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 3'h0;
      end else if (start) begin
         cnt_q <= `IMPS_RESUME_CYC;
      end else if (cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end
   end

   // Last count, so the owner acts on the next edge
   assign done = (cnt_q == 3'h1);

endmodule : imps_resume_timer

`default_nettype wire

// ===== dv/imps_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "imps_consts.svh"

module imps_ctrl_tb
   import imps_pkg::*;
;
   // ****************************************
   // Stimulus and observed ports
   // ****************************************
   logic          clk;
   logic          rst_n;
   imps_bus_req_t busReq;
   logic [15:0]   busRdata;
   logic          pwrSaveExec;
   logic          pwrSaveIdleOp;
   imps_wake_t    wake;
   logic          wdtEnable;
   logic          fscmEnable;
   logic          cpuRun;
   logic          cpuClkEn;
   logic          wdtClear;
   logic          lprcRun;
   logic          timer1Run;
   logic [7:0]    periphRun;
   logic [3:0]    dmaChanEn;
   imps_resume_t  resumeInfo;
   logic [15:0]   rdv;
   int            miscompares;
   int            n_checks;

   imps_ctrl imps_ctrl_i (
      .clk(clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
      .pwrSaveExec(pwrSaveExec), .pwrSaveIdleOp(pwrSaveIdleOp), .wake(wake),
      .wdtEnable(wdtEnable), .fscmEnable(fscmEnable), .cpuRun(cpuRun),
      .cpuClkEn(cpuClkEn), .wdtClear(wdtClear), .lprcRun(lprcRun),
      .timer1Run(timer1Run), .periphRun(periphRun), .dmaChanEn(dmaChanEn),
      .resumeInfo(resumeInfo)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ****************************************
   // Shared helpers
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk);
      busReq.we <= 1'b0;
   endtask : wr

   // Read data stands one cycle only, so sample right after that edge
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
      @(posedge clk);
      busReq.re <= 1'b0;
      #1;
      d = busRdata;
   endtask : rd

   // Irq held over the exec and entry cycles, to prove it waits for idle
   task automatic enterIdle(input logic withIrq);
      @(posedge clk);
      pwrSaveExec   <= 1'b1;
      pwrSaveIdleOp <= 1'b1;
      wake.irq      <= withIrq;
      @(posedge clk);
      pwrSaveExec   <= 1'b0;
      pwrSaveIdleOp <= 1'b0;
      #1;
      chk(cpuRun, 16'h0000);
      chk(wdtClear, 16'h0001);
      @(posedge clk);
      wake.irq <= 1'b0;
      #1;
      chk(cpuClkEn, 16'h0000);
      chk(wdtClear, 16'h0000);
   endtask : enterIdle

   task automatic resumeCheck(input logic isr);
      int n = 0;
      chk(cpuClkEn, 16'h0001);
      while (cpuRun !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(16'(n >= `IMPS_RESUME_MIN && n <= `IMPS_RESUME_MAX), 16'h0001);
      chk(resumeInfo.valid, 16'h0001);
      chk(resumeInfo.toIsr, 16'(isr));
      @(posedge clk);
      #1;
      chk(resumeInfo.valid, 16'h0000);
   endtask : resumeCheck

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic resetValues();
      #1;
      chk({cpuRun, cpuClkEn, wdtClear, lprcRun, timer1Run}, 16'h0019);
      chk({periphRun, dmaChanEn}, 16'h0fff);
      rd(`IMPS_ADDR_PDC7, rdv);
      chk(rdv, 16'h0000);
      rd(`IMPS_ADDR_TMR1CTL, rdv);
      chk(rdv, 16'h0000);
      wr(8'h09, 16'hffff);
      rd(8'h09, rdv);
      chk(rdv, 16'h0000);
      chk(dmaChanEn, 16'h000f);
   endtask : resetValues

   task automatic dmaDisable();
      wr(`IMPS_ADDR_PDC7, 16'h0010);
      rd(`IMPS_ADDR_PDC7, rdv);
      chk(rdv, 16'h0010);
      chk(dmaChanEn, 16'h0000);
      wr(`IMPS_ADDR_PDC7, 16'hffef);
      rd(`IMPS_ADDR_PDC7, rdv);
      chk(rdv, 16'h0000);
      chk(dmaChanEn, 16'h000f);
      wr(`IMPS_ADDR_PDC7, 16'hffff);
      rd(`IMPS_ADDR_PDC7, rdv);
      chk(rdv, 16'h0010);
   endtask : dmaDisable

   task automatic operandSleep();
      @(posedge clk);
      pwrSaveExec <= 1'b1;
      @(posedge clk);
      pwrSaveExec <= 1'b0;
      repeat (3) begin
         @(posedge clk);
         #1;
         chk({cpuRun, cpuClkEn, wdtClear}, 16'h0006);
      end
   endtask : operandSleep

   task automatic irqWake();
      wr(`IMPS_ADDR_TMR1CTL, 16'hffff);
      wr(`IMPS_ADDR_IDLESTOP, 16'h00a5);
      rd(`IMPS_ADDR_TMR1CTL, rdv);
      chk(rdv, 16'h2000);
      chk({timer1Run, periphRun}, 16'h01ff);
      @(posedge clk);
      wdtEnable  <= 1'b0;
      fscmEnable <= 1'b1;
      enterIdle(1'b0);
      chk({timer1Run, periphRun}, 16'h005a);
      chk(lprcRun, 16'h0001);
      rd(`IMPS_ADDR_STATUS, rdv);
      chk(rdv, 16'h0001);
      chk(cpuRun, 16'h0000);
      @(posedge clk);
      wake.irq <= 1'b1;
      @(posedge clk);
      wake.irq <= 1'b0;
      #1;
      resumeCheck(1'b1);
      chk({timer1Run, periphRun}, 16'h01ff);
      rd(`IMPS_ADDR_STATUS, rdv);
      chk(rdv, 16'h0002);
   endtask : irqWake

   task automatic coincidentIrq();
      enterIdle(1'b1);
      @(posedge clk);
      #1;
      resumeCheck(1'b1);
   endtask : coincidentIrq

   task automatic watchdogWake();
      wr(`IMPS_ADDR_TMR1CTL, 16'h0000);
      wr(`IMPS_ADDR_IDLESTOP, 16'h0000);
      @(posedge clk);
      wdtEnable  <= 1'b1;
      fscmEnable <= 1'b0;
      enterIdle(1'b0);
      chk(lprcRun, 16'h0001);
      chk({timer1Run, periphRun}, 16'h01ff);
      @(posedge clk);
      wake.wdtTimeout <= 1'b1;
      @(posedge clk);
      wake.wdtTimeout <= 1'b0;
      #1;
      resumeCheck(1'b0);
      rd(`IMPS_ADDR_STATUS, rdv);
      chk(rdv, 16'h0004);
   endtask : watchdogWake

   task automatic resetInIdle();
      enterIdle(1'b0);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk({cpuRun, cpuClkEn, dmaChanEn}, 16'h003f);
      rd(`IMPS_ADDR_PDC7, rdv);
      chk(rdv, 16'h0000);
   endtask : resetInIdle

   // ****************************************
   // Verdict and sequence
   // ****************************************
   task automatic conclude();
      if (miscompares == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      conclude();
   end

   initial begin
      miscompares   = 0;
      n_checks      = 0;
      rst_n         = 1'b0;
      busReq        = '0;
      pwrSaveExec   = 1'b0;
      pwrSaveIdleOp = 1'b0;
      wake          = '0;
      wdtEnable     = 1'b0;
      fscmEnable    = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      resetValues();
      dmaDisable();
      operandSleep();
      irqWake();
      coincidentIrq();
      watchdogWake();
      resetInIdle();
      conclude();
   end

endmodule : imps_ctrl_tb
`default_nettype wire
